// [mgic_device.sv]
// Glue chip end: controller register window, reset outputs, ISA side
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module mgic_device #(
  parameter int RTC_HALF = mgic_pkg::RTC_HALF_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Board pins
  input  wire logic       i_power_stable,
  input  wire logic       i_forced_reset,
  input  wire logic       i_host_cpu_reset_status,
  // ISA side
  input  wire logic       i_isa_chip_select_n,
  input  wire logic       i_alt_isa_chip_select_n,
  input  wire logic [2:0] i_isa_addr,
  input  wire logic       i_isa_wr_n,
  input  wire logic [7:0] i_isa_wdata,
  output logic      [7:0] o_isa_rdata,
  // Controller pins
  mgic_if.device          bus
);
  logic [2:0]  pg_s, fr_s, rs_s, rd_s, wr_s, cs_s, acs_s, iw_s;
  logic        pg, rd_n, wr_n, isa_sel, isa_wr_q;
  logic [7:0]  ctl, flags, isa_data, rd_val;
  logic [15:0] rtc_cnt;
  logic        rtc_lvl, hit;
  logic [7:0]  pins;

  // Two-stage synchronisers; bit 2 is an edge history
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {pg_s, fr_s, rs_s} <= '0;
      // Active-low pins start at their idle level: no false select
      {rd_s, wr_s, iw_s, cs_s, acs_s} <= '1;
    end else begin
      pg_s  <= {pg_s[1:0], i_power_stable};
      fr_s  <= {fr_s[1:0], i_forced_reset};
      rs_s  <= {rs_s[1:0], i_host_cpu_reset_status};
      rd_s  <= {rd_s[1:0], bus.ctrl_read_strobe_n};
      wr_s  <= {wr_s[1:0], bus.ctrl_write_strobe_n};
      cs_s  <= {cs_s[1:0], i_isa_chip_select_n};
      acs_s <= {acs_s[1:0], i_alt_isa_chip_select_n};
      iw_s  <= {iw_s[1:0], i_isa_wr_n};
    end
  end
  assign pg      = pg_s[1];
  assign rd_n    = rd_s[1];
  assign wr_n    = wr_s[1];
  assign isa_sel = !cs_s[1] || !acs_s[1];
  // Code fetches never hit the window [RQ5]
  assign hit = (bus.ctrl_address_bus[16:8] == mgic_pkg::CTRL_BASE[16:8])
               && bus.ctrl_code_fetch_n; // [RQ2]
  assign pins = {7'h00, rs_s[1]};

  // Latched registers; cleared while power is bad and stay clear [RQ16] [RQ17]
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !pg) begin
      ctl <= mgic_pkg::REG_RESET;
      flags <= mgic_pkg::REG_RESET;
    end else begin
      if (!wr_n && wr_s[2] && hit) begin // [RQ4]
        case (bus.ctrl_address_bus[7:0])
          mgic_pkg::REG_CTRL:  ctl <= bus.ctrl_data_bus; // [RQ8]
          mgic_pkg::REG_FLAGS: flags <= bus.ctrl_data_bus;
          default: ;
        endcase
      end
      // Host write to ISA address 0 marks busy; set beats a same-cycle clear
      if (isa_wr_q) begin
        flags[mgic_pkg::FLG_BUSY] <= 1'b1;
      end
    end
  end

  // ISA side decodes only three address bits [RQ18]
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !pg) begin
      isa_data <= mgic_pkg::REG_RESET;
      isa_wr_q <= 1'b0;
      o_isa_rdata <= 8'h00;
    end else begin
      isa_wr_q <= isa_sel && !iw_s[1] && iw_s[2] && (i_isa_addr == 3'h0);
      if (isa_sel && !iw_s[1] && iw_s[2] && (i_isa_addr == 3'h0))
        isa_data <= i_isa_wdata;
      case (i_isa_addr)
        3'h0:    o_isa_rdata <= isa_data;
        3'h1:    o_isa_rdata <= flags;
        default: o_isa_rdata <= 8'h00;
      endcase
    end
  end

  always_comb begin
    case (bus.ctrl_address_bus[7:0])
      mgic_pkg::REG_CTRL:    rd_val = ctl;
      mgic_pkg::REG_FLAGS:   rd_val = flags;
      mgic_pkg::REG_PINS:    rd_val = pins;
      mgic_pkg::REG_ISADATA: rd_val = isa_data;
      default:               rd_val = 8'h00;
    endcase
  end

  // Read data and bus drive [RQ1] [RQ3]
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus.data_from_dev <= 8'h00;
      bus.data_oe_dev_n <= 1'b1;
    end else begin
      bus.data_oe_dev_n <= !(!rd_n && hit);
      bus.data_from_dev <= pg ? rd_val : 8'h00; // [RQ16]
    end
  end

  // Slow clock divider
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rtc_cnt <= '0;
      rtc_lvl <= 1'b0;
    end else if (rtc_cnt == 16'(RTC_HALF - 1)) begin
      rtc_cnt <= '0;
      rtc_lvl <= !rtc_lvl;
    end else begin
      rtc_cnt <= rtc_cnt + 16'h0001;
    end
  end

  // Board outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus.system_reset_indicator <= 1'b0;
      bus.backplane_reset_n      <= 1'b0;
      bus.power_dist_reset_n     <= 1'b0;
      bus.soft_error_n           <= 1'b1;
      bus.spi_reset_n            <= 1'b1;
      bus.ctrl_interrupt_n       <= 1'b1;
      bus.system_power_ok_hold   <= 1'b0;
      bus.ctrl_reset_n           <= 1'b0;
    end else begin
      bus.system_reset_indicator <= !rs_s[1]; // [RQ7]
      bus.backplane_reset_n      <= ctl[mgic_pkg::CTL_BP_RST]; // [RQ8]
      bus.power_dist_reset_n     <= ctl[mgic_pkg::CTL_PD_RST]; // [RQ9]
      bus.soft_error_n           <= !ctl[mgic_pkg::CTL_SERR]; // [RQ10]
      // Toggle during power loss or forced reset, else steady high [RQ11] [RQ15]
      bus.spi_reset_n            <= (!pg || fr_s[1]) ? rtc_lvl : 1'b1;
      bus.ctrl_interrupt_n       <= !flags[mgic_pkg::FLG_BUSY]; // [RQ12]
      bus.system_power_ok_hold   <= pg && ctl[mgic_pkg::CTL_PWR_HOLD]; // [RQ13] [RQ16]
      bus.ctrl_reset_n           <= pg; // [RQ16]
    end
  end
endmodule
`default_nettype wire

// [mgic_pkg.sv]
// Shared constants and the function list for the management interface glue
// Function
// RQ1: Device drives data bus only on reads
// RQ2: Controller presents 16-bit address plus page bit
// RQ3: Low read strobe means register read
// RQ4: Low write strobe means register write
// RQ5: Code fetch strobe only for instruction fetches
// RQ6: Reset status high while host CPUs reset
// RQ7: Reset indicator is inverse of reset status
// RQ8: Backplane reset bit writable, readable, drives low
// RQ9: Power distribution reset driven low on command
// RQ10: Soft error output driven low on error
// RQ11: SPI reset toggles at slow clock rate
// RQ12: Interrupt output is inverse of busy bit
// RQ13: Power ok hold low holds system reset
// RQ14: Bridge drives ISA select low on hits
// RQ15: SPI reset steady high when power normal
// RQ16: Power loss: registers read zero, resets held
// RQ17: Latched registers stay zero, pins read live
// RQ18: ISA access decodes address bits 0-2 only
`default_nettype none
package mgic_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 17;
  localparam int          ISA_ADDR_W   = 3;
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          RTC_HZ       = 32_768;
  // Half period of the slow clock, in system cycles
  localparam int          RTC_HALF_CYC = CLK_HZ / (2 * RTC_HZ);
  // Controller-side register window (base page, arbitrary)
  localparam logic [16:0] CTRL_BASE    = 17'h0_FF00;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_FLAGS    = 8'h01;
  localparam logic [7:0]  REG_PINS     = 8'h02;
  localparam logic [7:0]  REG_ISADATA  = 8'h03;
  // Control and flags register bit positions, register reset value
  localparam int          CTL_BP_RST   = 0;
  localparam int          CTL_PD_RST   = 1;
  localparam int          CTL_SERR     = 2;
  localparam int          CTL_PWR_HOLD = 3;
  localparam int          FLG_BUSY     = 0;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  // Host APB map
  localparam logic [11:0] APB_CMD      = 12'h000;
  localparam logic [11:0] APB_ARG      = 12'h004;
  localparam logic [11:0] APB_RDATA    = 12'h008;
  localparam logic [11:0] APB_STAT     = 12'h00C;
  localparam logic [11:0] APB_IRQ_ST   = 12'h010;
  localparam logic [11:0] APB_IRQ_MSK  = 12'h014;
  localparam logic [11:0] APB_PINS     = 12'h018;
  // Flags sit above the full 17-bit address so the page bit stays free
  localparam int          CMD_WRITE    = 17;
  localparam int          CMD_FETCH    = 18;
  localparam int          STROBE_CYC   = 4;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_CTRL_INT = 1;
endpackage
`default_nettype wire

// [mgic_if.sv]
// Pin interface between the glue chip and the management controller
`timescale 1ns/10ps
`default_nettype none
interface mgic_if;
  logic [7:0]  data_from_ctrl;
  logic        data_oe_ctrl_n;
  logic [7:0]  data_from_dev;
  logic        data_oe_dev_n;
  logic [16:0] ctrl_address_bus;
  logic        ctrl_read_strobe_n;
  logic        ctrl_write_strobe_n;
  logic        ctrl_code_fetch_n;
  logic        ctrl_interrupt_n;
  logic        host_cpu_reset_status;
  logic        system_reset_indicator;
  logic        backplane_reset_n;
  logic        power_dist_reset_n;
  logic        soft_error_n;
  logic        spi_reset_n;
  logic        system_power_ok_hold;
  logic        ctrl_reset_n;
  logic [7:0]  ctrl_data_bus;
  // Resolved bus: whichever end enables drives, the device if both do; idle pulls high
  assign ctrl_data_bus = !data_oe_dev_n  ? data_from_dev :
                         !data_oe_ctrl_n ? data_from_ctrl : 8'hFF;
  modport device (
    input  ctrl_data_bus, ctrl_address_bus, ctrl_read_strobe_n, ctrl_write_strobe_n,
    input  ctrl_code_fetch_n, host_cpu_reset_status,
    output data_from_dev, data_oe_dev_n, ctrl_interrupt_n, system_reset_indicator,
    output backplane_reset_n, power_dist_reset_n, soft_error_n, spi_reset_n,
    output system_power_ok_hold, ctrl_reset_n
  );
  modport controller (
    input  ctrl_data_bus, ctrl_interrupt_n, system_reset_indicator, backplane_reset_n,
    input  power_dist_reset_n, soft_error_n, spi_reset_n, system_power_ok_hold,
    input  ctrl_reset_n,
    output data_from_ctrl, data_oe_ctrl_n, ctrl_address_bus, ctrl_read_strobe_n,
    output ctrl_write_strobe_n, ctrl_code_fetch_n
  );
endinterface
`default_nettype wire

// [mgic_controller.sv]
// Controller end: APB-programmed bus master for the glue chip pins
`timescale 1ns/10ps
`default_nettype none
module mgic_controller (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  // Chip pins
  mgic_if.controller       bus
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_STROBE = 2'b01, S_END = 2'b11} mgic_state_t;
  mgic_state_t st;
  logic [18:0] cmd;
  logic [7:0]  arg, rdata;
  logic [2:0]  cnt;
  logic [1:0]  irq_st, irq_msk;
  logic [1:0]  int_s;
  logic        int_q, go, done;
  logic [7:0]  pins;

  assign go = i_psel && i_penable && i_pwrite && (i_paddr == mgic_pkg::APB_CMD)
              && st == S_IDLE;
  assign done = st == S_END;
  assign pins = {bus.ctrl_reset_n, bus.system_power_ok_hold, bus.spi_reset_n,
                 bus.soft_error_n, bus.power_dist_reset_n, bus.backplane_reset_n,
                 bus.system_reset_indicator, bus.ctrl_interrupt_n};

  // Strobe sequencer; only one strobe low at a time [RQ3] [RQ4] [RQ5]
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= S_IDLE;
      cmd <= '0;
      cnt <= '0;
      rdata <= 8'h00;
      bus.ctrl_address_bus <= '0;
      bus.ctrl_read_strobe_n <= 1'b1;
      bus.ctrl_write_strobe_n <= 1'b1;
      bus.ctrl_code_fetch_n <= 1'b1;
      bus.data_oe_ctrl_n <= 1'b1;
      bus.data_from_ctrl <= 8'h00;
    end else begin
      case (st)
        S_IDLE: if (go) begin
          cmd <= i_pwdata[18:0];
          bus.ctrl_address_bus <= i_pwdata[16:0]; // [RQ2]
          bus.data_from_ctrl <= arg;
          bus.data_oe_ctrl_n <= !i_pwdata[mgic_pkg::CMD_WRITE];
          bus.ctrl_write_strobe_n <= !i_pwdata[mgic_pkg::CMD_WRITE];
          bus.ctrl_code_fetch_n <= !i_pwdata[mgic_pkg::CMD_FETCH]
                                   || i_pwdata[mgic_pkg::CMD_WRITE];
          bus.ctrl_read_strobe_n <= i_pwdata[mgic_pkg::CMD_WRITE]
                                    || i_pwdata[mgic_pkg::CMD_FETCH];
          cnt <= '0;
          st <= S_STROBE;
        end
        S_STROBE: begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'(mgic_pkg::STROBE_CYC - 1)) begin
            rdata <= bus.ctrl_data_bus;
            bus.ctrl_read_strobe_n <= 1'b1;
            bus.ctrl_write_strobe_n <= 1'b1;
            bus.ctrl_code_fetch_n <= 1'b1;
            st <= S_END;
          end
        end
        S_END: begin
          bus.data_oe_ctrl_n <= 1'b1;
          st <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // Argument register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst)
      arg <= 8'h00;
    else if (i_psel && i_penable && i_pwrite && i_paddr == mgic_pkg::APB_ARG)
      arg <= i_pwdata[7:0];
  end

  // Interrupt status: set wins over write-one clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      int_s <= 2'b11;
      int_q <= 1'b1;
      irq_st <= '0;
      irq_msk <= '0;
      o_irq <= 1'b0;
    end else begin
      int_s <= {int_s[0], bus.ctrl_interrupt_n};
      int_q <= int_s[1];
      if (i_psel && i_penable && i_pwrite && i_paddr == mgic_pkg::APB_IRQ_MSK)
        irq_msk <= i_pwdata[1:0];
      irq_st <= (irq_st & ~((i_psel && i_penable && i_pwrite
                 && i_paddr == mgic_pkg::APB_IRQ_ST) ? i_pwdata[1:0] : 2'b00))
                | {int_q && !int_s[1], done}; // [RQ12]
      o_irq <= |(irq_st & irq_msk);
    end
  end

  // APB read path, zero wait states
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      case (i_paddr)
        mgic_pkg::APB_CMD:     o_prdata <= {13'h0000, cmd};
        mgic_pkg::APB_ARG:     o_prdata <= {24'h000000, arg};
        mgic_pkg::APB_RDATA:   o_prdata <= {24'h000000, rdata};
        mgic_pkg::APB_STAT:    o_prdata <= {31'h00000000, st != S_IDLE};
        mgic_pkg::APB_IRQ_ST:  o_prdata <= {30'h00000000, irq_st};
        mgic_pkg::APB_IRQ_MSK: o_prdata <= {30'h00000000, irq_msk};
        mgic_pkg::APB_PINS:    o_prdata <= {24'h000000, pins};
        default:               o_prdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// [mgic_sva.sv]
// Assertions on the pin interface between the glue chip and the controller
`timescale 1ns/10ps
`default_nettype none
module mgic_sva #(
  parameter int RTC_HALF = 4
) (
  // Clock, reset and board pins
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic        i_power_stable,
  input wire logic        i_forced_reset,
  // Interface signals
  input wire logic        data_oe_dev_n,
  input wire logic [7:0]  ctrl_data_bus,
  input wire logic [16:0] ctrl_address_bus,
  input wire logic        ctrl_read_strobe_n,
  input wire logic        ctrl_write_strobe_n,
  input wire logic        ctrl_code_fetch_n,
  input wire logic        host_cpu_reset_status,
  input wire logic        system_reset_indicator,
  input wire logic        backplane_reset_n,
  input wire logic        power_dist_reset_n,
  input wire logic        soft_error_n,
  input wire logic        spi_reset_n,
  input wire logic        system_power_ok_hold,
  input wire logic        ctrl_reset_n
);
  logic [15:0] stable_cnt;
  logic        spi_prev;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Cycles since the SPI reset last moved, saturating
  always_ff @(posedge i_clk_sys) begin
    spi_prev <= spi_reset_n;
    if (i_sys_rst || spi_reset_n != spi_prev) stable_cnt <= 16'h0000;
    else if (stable_cnt != 16'hFFFF) stable_cnt <= stable_cnt + 16'h0001;
  end
  property ctrl_write_p;
    logic [7:0] d;
    ($fell(ctrl_write_strobe_n) && ctrl_code_fetch_n && ctrl_reset_n &&
     ctrl_address_bus == {mgic_pkg::CTRL_BASE[16:8], mgic_pkg::REG_CTRL}, d = ctrl_data_bus)
    |-> ##6 ({system_power_ok_hold, power_dist_reset_n, backplane_reset_n} == {d[3], d[1], d[0]}
             && (!d[2] || !soft_error_n));
  endproperty
  chk_bus_no_clash: assert property (!ctrl_write_strobe_n |-> data_oe_dev_n)
    else $error("device drives data bus during a write");
  chk_bus_read_only: assert property ($fell(data_oe_dev_n) |-> !ctrl_read_strobe_n)
    else $error("device drives data bus without a read");
  chk_ctrl_write_pins: assert property (ctrl_write_p)
    else $error("control write not reflected on pins");
  chk_indicator_inverse: assert property ((ctrl_reset_n && $stable(host_cpu_reset_status))[*6]
    |-> system_reset_indicator == !host_cpu_reset_status)
    else $error("reset indicator not inverse of status");
  chk_spi_toggles: assert property ((!i_power_stable || i_forced_reset)[*8] ##1
    (!i_power_stable || i_forced_reset)[*4] |-> stable_cnt <= RTC_HALF)
    else $error("SPI reset not toggling");
  chk_spi_steady: assert property ((i_power_stable && !i_forced_reset)[*8] |-> spi_reset_n)
    else $error("SPI reset not steady high");
  chk_power_bad_hold: assert property (!i_power_stable[*6]
    |-> !ctrl_reset_n && !system_power_ok_hold)
    else $error("resets not held while power bad");
  chk_latch_cleared: assert property ($rose(ctrl_reset_n) |-> !backplane_reset_n &&
    !power_dist_reset_n && soft_error_n && !system_power_ok_hold)
    else $error("latched control not clear on release");
  cov_ctrl_write: cover property (ctrl_write_p);
  cov_dev_read: cover property ($fell(data_oe_dev_n));
  cov_power_bad: cover property (!i_power_stable[*6]);
endmodule
`default_nettype wire

// [mgic_tb.sv]
// Self-checking bench joining both ends of the glue chip pin interface
`timescale 1ns/10ps
`default_nettype none
module mgic_tb;
  logic        clk, rst, power_ok, forced, cpu_rst, cs_n, acs_n, isa_wr_n;
  logic        psel, pen, pwrite, pready, pslverr, irq, spi_prev;
  logic [2:0]  isa_a;
  logic [7:0]  isa_wd, isa_rd, rd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          bad_count, samples_checked, n;
  int          cycles = 0;
  mgic_if i_mgic_if ();
  // Status pin also shown on the interface for the checker
  assign i_mgic_if.host_cpu_reset_status = cpu_rst;
  mgic_device #(.RTC_HALF(4)) i_mgic_device (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_power_stable(power_ok), .i_forced_reset(forced),
    .i_host_cpu_reset_status(cpu_rst), .i_isa_chip_select_n(cs_n),
    .i_alt_isa_chip_select_n(acs_n), .i_isa_addr(isa_a), .i_isa_wr_n(isa_wr_n),
    .i_isa_wdata(isa_wd), .o_isa_rdata(isa_rd), .bus(i_mgic_if.device));
  mgic_controller i_mgic_controller (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .bus(i_mgic_if.controller));
  mgic_sva #(.RTC_HALF(4)) i_mgic_sva (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_power_stable(power_ok), .i_forced_reset(forced),
    .data_oe_dev_n(i_mgic_if.data_oe_dev_n), .ctrl_data_bus(i_mgic_if.ctrl_data_bus),
    .ctrl_address_bus(i_mgic_if.ctrl_address_bus),
    .ctrl_read_strobe_n(i_mgic_if.ctrl_read_strobe_n),
    .ctrl_write_strobe_n(i_mgic_if.ctrl_write_strobe_n),
    .ctrl_code_fetch_n(i_mgic_if.ctrl_code_fetch_n),
    .host_cpu_reset_status(i_mgic_if.host_cpu_reset_status),
    .system_reset_indicator(i_mgic_if.system_reset_indicator),
    .backplane_reset_n(i_mgic_if.backplane_reset_n),
    .power_dist_reset_n(i_mgic_if.power_dist_reset_n),
    .soft_error_n(i_mgic_if.soft_error_n), .spi_reset_n(i_mgic_if.spi_reset_n),
    .system_power_ok_hold(i_mgic_if.system_power_ok_hold),
    .ctrl_reset_n(i_mgic_if.ctrl_reset_n));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Runaway guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      bad_count++;
    end
  endtask
  // One APB transfer; the idle edge at the end keeps back-to-back calls clean
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pen <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  // Controller cycle on the pins, waiting for done, then fetching its data
  task automatic dev(input logic wr, input logic [7:0] off, input logic [7:0] wd);
    logic [31:0] cmd;
    cmd = {14'h0, 1'h0, mgic_pkg::CTRL_BASE[16:8], off};
    cmd[mgic_pkg::CMD_WRITE] = wr;
    apb(1'h1, mgic_pkg::APB_ARG, {24'h0, wd});
    apb(1'h1, mgic_pkg::APB_CMD, cmd);
    r = 32'h0;
    while (r[0] !== 1'h1) apb(1'h0, mgic_pkg::APB_IRQ_ST, 32'h0);
    apb(1'h1, mgic_pkg::APB_IRQ_ST, 32'h1);
    apb(1'h0, mgic_pkg::APB_RDATA, 32'h0);
    rd = r[7:0];
  endtask
  task automatic isa(input logic alt, input logic [2:0] a, input logic wr);
    cs_n <= alt;
    acs_n <= !alt;
    isa_a <= a;
    isa_wr_n <= !wr;
    isa_wd <= 8'h3C;
    repeat (8) @(posedge clk);
    rd = isa_rd;
    cs_n <= 1'h1;
    acs_n <= 1'h1;
    isa_wr_n <= 1'h1;
    @(posedge clk);
  endtask
  initial begin
    {rst, power_ok, cs_n, acs_n, isa_wr_n} = 5'h1F;
    {forced, cpu_rst, psel, pen, pwrite, isa_a, isa_wd, paddr, pwdata} = 60'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, mgic_pkg::APB_STAT, 32'h0);
    chk("stat", 32'h0, r);
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h0, r);
    chk("spi_idle", 32'h1, {31'h0, i_mgic_if.spi_reset_n});
    $display("Test reset state done");
    for (int b = 0; b < 4; b++) begin
      dev(1'h1, mgic_pkg::REG_CTRL, 8'h01 << b);
      dev(1'h0, mgic_pkg::REG_CTRL, 8'h00);
      chk("ctrl_readback", 32'h1, {31'h0, rd[b]});
      chk("ctrl_pins", {b == 3, b == 1, b == 0}, {i_mgic_if.system_power_ok_hold,
          i_mgic_if.power_dist_reset_n, i_mgic_if.backplane_reset_n});
      if (b == 2) chk("soft_err", 32'h0, {31'h0, i_mgic_if.soft_error_n});
    end
    $display("Test control pins done");
    for (int v = 1; v >= 0; v--) begin
      cpu_rst <= v[0];
      repeat (8) @(posedge clk);
      chk("indicator", {31'h0, !v[0]}, {31'h0, i_mgic_if.system_reset_indicator});
      dev(1'h0, mgic_pkg::REG_PINS, 8'h00);
      chk("pins_reg", {31'h0, v[0]}, {31'h0, rd[0]});
    end
    $display("Test reset indicator done");
    // Code fetch must leave the data bus to its idle level
    apb(1'h1, mgic_pkg::APB_IRQ_MSK, 32'h1);
    apb(1'h1, mgic_pkg::APB_CMD, {13'h0, 1'h1, 2'h0, 8'hFF, mgic_pkg::REG_CTRL});
    repeat (10) @(posedge clk);
    chk("irq_done", 32'h1, {31'h0, irq});
    apb(1'h1, mgic_pkg::APB_IRQ_MSK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'h1, mgic_pkg::APB_IRQ_MSK, 32'h1);
    apb(1'h1, mgic_pkg::APB_IRQ_ST, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    apb(1'h0, mgic_pkg::APB_RDATA, 32'h0);
    chk("fetch_data", 32'hFF, {24'h0, r[7:0]});
    $display("Test interrupt and fetch done");
    // Host writes the data port; only the host side writes it
    isa(1'h1, 3'h0, 1'h1);
    repeat (4) @(posedge clk);
    chk("ctrl_int", 32'h0, {31'h0, i_mgic_if.ctrl_interrupt_n});
    apb(1'h0, mgic_pkg::APB_IRQ_ST, 32'h0);
    chk("irq_ctrl_int", 32'h1, {31'h0, r[mgic_pkg::IRQ_CTRL_INT]});
    dev(1'h0, mgic_pkg::REG_ISADATA, 8'h00);
    chk("isa_to_ctrl", 32'h3C, {24'h0, rd});
    isa(1'h0, 3'h0, 1'h0);
    chk("isa_data", 32'h3C, {24'h0, rd});
    dev(1'h0, mgic_pkg::REG_FLAGS, 8'h00);
    chk("flags_busy", 32'h1, {31'h0, rd[0]});
    for (int a = 1; a < 8; a++) begin
      isa(a[0], a[2:0], 1'h0);
      chk("isa_reg", {31'h0, a == 1}, {24'h0, rd});
    end
    $display("Test isa side done");
    forced <= 1'h1;
    repeat (10) @(posedge clk);
    n = 0;
    spi_prev = i_mgic_if.spi_reset_n;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i_mgic_if.spi_reset_n !== spi_prev) n++;
      spi_prev = i_mgic_if.spi_reset_n;
    end
    chk("spi_toggles", 32'h1, {31'h0, n >= 8});
    forced <= 1'h0;
    repeat (12) @(posedge clk);
    chk("spi_steady", 32'h1, {31'h0, i_mgic_if.spi_reset_n});
    $display("Test SPI reset done");
    dev(1'h1, mgic_pkg::REG_CTRL, 8'h0B);
    power_ok <= 1'h0;
    repeat (8) @(posedge clk);
    chk("power_bad", 32'h0, {30'h0, i_mgic_if.ctrl_reset_n,
        i_mgic_if.system_power_ok_hold});
    power_ok <= 1'h1;
    cpu_rst <= 1'h1;
    repeat (10) @(posedge clk);
    dev(1'h0, mgic_pkg::REG_CTRL, 8'h00);
    chk("ctrl_cleared", 32'h0, {24'h0, rd});
    dev(1'h0, mgic_pkg::REG_PINS, 8'h00);
    chk("pins_live", 32'h1, {31'h0, rd[0]});
    $display("Test power loss done");
    stop_test();
  end
endmodule
`default_nettype wire
